// *** crrso_pkg.sv ***
// Package with opcodes, field positions, reset values and timing constants.
package crrso_pkg;
  // ----------------------------------------------------------------------
  // Instruction encoding
  // ----------------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int PC_W = 13;
  localparam int WDOG_W = 8;
  localparam int PRE_W = 8;
  // Operations this block executes.
  typedef enum logic [2:0] {
    CRRSO_OP_NONE,
    CRRSO_OP_RETLIT,
    CRRSO_OP_RETURN,
    CRRSO_OP_ROTR,
    CRRSO_OP_SLEEP,
    CRRSO_OP_SUBLIT,
    CRRSO_OP_XORLIT
  } crrso_op_t;
  // Field positions within an 8-bit datum.
  localparam int MSB_POS = 7;
  localparam int LSB_POS = 0;
  localparam int NIB_MSB = 3;
  // Reset and clear values.
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [WDOG_W-1:0] WDOG_CLEAR = 8'h00;
  localparam logic [PRE_W-1:0] PRE_CLEAR = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  // Timing: two-cycle returns need one extra flush cycle.
  localparam int RET_CYCLES = 2;
  localparam logic [1:0] RET_EXTRA = 2'(RET_CYCLES - 1);
endpackage

// *** crrso_alu.sv ***
// Combinational datapath for rotate, subtract-from-literal and xor-literal.
`timescale 1ns/1ps
`default_nettype none
module crrso_alu (
  // Operation select and operands.
  input wire crrso_pkg::crrso_op_t op,
  input wire logic [7:0] lit,
  input wire logic [7:0] acc,
  input wire logic [7:0] fileVal,
  input wire logic carryIn,
  // Results and flags.
  output logic [7:0] result,
  output logic carryOut,
  output logic digitOut,
  output logic zeroOut
);
  import crrso_pkg::*;

  // ----------------------------------------------------------------------
  // Arithmetic terms
  // ----------------------------------------------------------------------
  // Nine-bit sum of lit plus ones-complement acc plus one; bit 8 is no-borrow.
  wire logic [8:0] subFull;
  wire logic [4:0] subLow;
  wire logic [7:0] rotVal;
  wire logic [7:0] xorVal;
  assign subFull = {1'b0, lit} + {1'b0, ~acc} + 9'h001;
  assign subLow = {1'b0, lit[NIB_MSB:0]} + {1'b0, ~acc[NIB_MSB:0]} + 5'h01;
  assign rotVal = {carryIn, fileVal[MSB_POS:1]};
  assign xorVal = acc ^ lit;

  // ----------------------------------------------------------------------
  // Result select
  // ----------------------------------------------------------------------
  // Carry follows the rotated-out bit or the no-borrow bit; else held.
  always_comb begin
    result = acc;
    carryOut = carryIn;
    digitOut = 1'b0;
    case (op)
      CRRSO_OP_ROTR: begin
        result = rotVal;
        carryOut = fileVal[LSB_POS];
      end
      CRRSO_OP_SUBLIT: begin
        result = subFull[7:0];
        carryOut = subFull[8];
        digitOut = subLow[4];
      end
      CRRSO_OP_XORLIT: begin
        result = xorVal;
      end
      default: begin
        result = acc;
      end
    endcase
  end
  assign zeroOut = (result == ZERO_BYTE);
endmodule
`default_nettype wire

// *** crrso_core.sv ***
// Execution unit for returns, rotate-right, sleep, subtract and xor literal.
`timescale 1ns/1ps
`default_nettype none
module crrso_core (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Decoded instruction, one-cycle strobe.
  input wire logic instValid,
  input wire crrso_pkg::crrso_op_t instOp,
  input wire logic [7:0] instLiteral,
  input wire logic [6:0] instFileAddr,
  input wire logic instDestFile,
  // Return stack and file register partner.
  input wire logic [12:0] stackTopEntry,
  input wire logic [7:0] fileReadData,
  // Wake request from outside logic leaves sleep.
  input wire logic wakeReq,
  // Accumulator and flags.
  output logic [7:0] accOut,
  output logic carryFlag,
  output logic digitCarryFlag,
  output logic zeroFlag,
  output logic timeoutStatusBit,
  output logic powerdownStatusBit,
  // Program counter and stack pop.
  output logic [12:0] pcOut,
  output logic pcLoad,
  output logic stackPop,
  // File register write port: write address, strobe and data.
  output logic [6:0] fileAddr,
  output logic fileWrEn,
  output logic [7:0] fileWrData,
  // Watchdog control, sleep state and busy.
  output logic watchdogClear,
  output logic oscHalt,
  output logic busy
);
  import crrso_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  // Flush runs the second cycle of a two-cycle return.
  typedef enum logic [1:0] {CRRSO_RUN, CRRSO_FLUSH, CRRSO_SLEEP} crrso_st_t;
  crrso_st_t state_q, state_d; // Sequencer state.
  logic [7:0] acc_q, acc_d; // Working accumulator.
  logic carry_q, carry_d; // Carry flag.
  logic digit_q, digit_d; // Digit carry flag.
  logic zero_q, zero_d; // Zero flag.
  logic to_q, to_d; // Time-out status.
  logic pwrDn_q, pwrDn_d; // Power-down status, active when clear.
  logic [12:0] pc_q, pc_d; // Program counter value handed out.
  logic pcLoad_q, pcLoad_d; // Program counter load strobe.
  logic pop_q, pop_d; // Stack pop strobe.
  logic [6:0] fa_q, fa_d; // File address.
  logic fwe_q, fwe_d; // File write strobe.
  logic [7:0] fwd_q, fwd_d; // File write data.
  logic wdc_q, wdc_d; // Watchdog and prescaler clear strobe.

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  // Only instructions arriving in the run state are accepted.
  wire logic accept;
  wire logic isRet;
  wire logic [7:0] aluRes;
  wire logic aluC;
  wire logic aluDigit;
  wire logic aluZ;
  wire crrso_op_t aluOp;
  assign accept = instValid && (state_q == CRRSO_RUN);
  assign isRet = (instOp == CRRSO_OP_RETLIT) || (instOp == CRRSO_OP_RETURN);
  assign aluOp = accept ? instOp : CRRSO_OP_NONE;

  // The file value arrives combinationally for the addressed register.
  crrso_alu u_alu (
    .op(aluOp),
    .lit(instLiteral),
    .acc(acc_q),
    .fileVal(fileReadData),
    .carryIn(carry_q),
    .result(aluRes),
    .carryOut(aluC),
    .digitOut(aluDigit),
    .zeroOut(aluZ)
  );

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Strobes default low; flags hold unless the operation names them.
  always_comb begin
    state_d = state_q;
    acc_d = acc_q;
    carry_d = carry_q;
    digit_d = digit_q;
    zero_d = zero_q;
    to_d = to_q;
    pwrDn_d = pwrDn_q;
    pc_d = pc_q;
    pcLoad_d = 1'b0;
    pop_d = 1'b0;
    fa_d = instFileAddr;
    fwe_d = 1'b0;
    fwd_d = fwd_q;
    wdc_d = 1'b0;
    case (state_q)
      CRRSO_RUN: begin
        if (accept) begin
          case (instOp)
            CRRSO_OP_RETLIT: begin
              acc_d = instLiteral;
              pc_d = stackTopEntry;
              pcLoad_d = 1'b1;
              pop_d = 1'b1;
            end
            CRRSO_OP_RETURN: begin
              pc_d = stackTopEntry;
              pcLoad_d = 1'b1;
              pop_d = 1'b1;
            end
            CRRSO_OP_ROTR: begin
              carry_d = aluC;
              if (instDestFile) begin
                fwe_d = 1'b1;
                fwd_d = aluRes;
              end else begin
                acc_d = aluRes;
              end
            end
            CRRSO_OP_SLEEP: begin
              wdc_d = 1'b1;
              to_d = 1'b1;
              pwrDn_d = 1'b0;
              state_d = CRRSO_SLEEP;
            end
            CRRSO_OP_SUBLIT: begin
              acc_d = aluRes;
              carry_d = aluC;
              digit_d = aluDigit;
              zero_d = aluZ;
            end
            CRRSO_OP_XORLIT: begin
              acc_d = aluRes;
              zero_d = aluZ;
            end
            default: begin
              state_d = CRRSO_RUN;
            end
          endcase
          if (isRet) begin
            state_d = CRRSO_FLUSH;
          end
        end
      end
      // Second cycle of a return: the fetched word is discarded.
      CRRSO_FLUSH: begin
        state_d = CRRSO_RUN;
      end
      // Sleep lasts until outside wake logic restarts the oscillator.
      CRRSO_SLEEP: begin
        if (wakeReq) begin
          state_d = CRRSO_RUN;
        end
      end
      default: begin
        state_d = CRRSO_RUN;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Status bits reset to the no-event values: both set.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= CRRSO_RUN;
      acc_q <= ACC_RST;
      carry_q <= 1'b0;
      digit_q <= 1'b0;
      zero_q <= 1'b0;
      to_q <= 1'b1;
      pwrDn_q <= 1'b1;
      pc_q <= PC_RST;
      pcLoad_q <= 1'b0;
      pop_q <= 1'b0;
      fa_q <= '0;
      fwe_q <= 1'b0;
      fwd_q <= ZERO_BYTE;
      wdc_q <= 1'b0;
    end else begin
      state_q <= state_d;
      acc_q <= acc_d;
      carry_q <= carry_d;
      digit_q <= digit_d;
      zero_q <= zero_d;
      to_q <= to_d;
      pwrDn_q <= pwrDn_d;
      pc_q <= pc_d;
      pcLoad_q <= pcLoad_d;
      pop_q <= pop_d;
      fa_q <= fa_d;
      fwe_q <= fwe_d;
      fwd_q <= fwd_d;
      wdc_q <= wdc_d;
    end
  end

  // Busy and halt are registered copies of the state for direct output.
  logic busy_q; // Not ready for a new instruction.
  logic halt_q; // Oscillator halted.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      halt_q <= 1'b0;
    end else begin
      busy_q <= (state_d != CRRSO_RUN);
      halt_q <= (state_d == CRRSO_SLEEP);
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign accOut = acc_q;
  assign carryFlag = carry_q;
  assign digitCarryFlag = digit_q;
  assign zeroFlag = zero_q;
  assign timeoutStatusBit = to_q;
  assign powerdownStatusBit = pwrDn_q;
  assign pcOut = pc_q;
  assign pcLoad = pcLoad_q;
  assign stackPop = pop_q;
  assign fileAddr = fa_q;
  assign fileWrEn = fwe_q;
  assign fileWrData = fwd_q;
  assign watchdogClear = wdc_q;
  assign oscHalt = halt_q;
  assign busy = busy_q;
endmodule
`default_nettype wire

// *** crrso_properties.sv ***
// Concurrent checks on the execution unit ports.
`timescale 1ns/1ps
`default_nettype none
module crrso_properties (
  // Clock, reset and instruction.
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic instValid,
  input wire crrso_pkg::crrso_op_t instOp,
  input wire logic [7:0] instLiteral,
  input wire logic instDestFile,
  input wire logic [12:0] stackTopEntry,
  input wire logic [7:0] fileReadData,
  // Results.
  input wire logic [7:0] accOut,
  input wire logic carryFlag,
  input wire logic digitCarryFlag,
  input wire logic zeroFlag,
  input wire logic timeoutStatusBit,
  input wire logic powerdownStatusBit,
  input wire logic [12:0] pcOut,
  input wire logic pcLoad,
  input wire logic stackPop,
  input wire logic fileWrEn,
  input wire logic [7:0] fileWrData,
  input wire logic watchdogClear,
  input wire logic oscHalt,
  input wire logic busy
);
  import crrso_pkg::*;
  // ----
  // Checks
  // ----
  // An instruction counts only when the unit is free.
  wire logic tk = instValid && !busy;
  wire logic rot = tk && instOp == CRRSO_OP_ROTR;
  wire logic ret = tk && (instOp == CRRSO_OP_RETLIT ||
    instOp == CRRSO_OP_RETURN);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // A return holds the port for exactly one extra cycle.
  sequence seqRet;
    busy && pcLoad && stackPop ##1 !busy && !stackPop;
  endsequence
  AST_RETLIT:
    assert property (tk && instOp == CRRSO_OP_RETLIT |=>
      accOut == $past(instLiteral)) else $error("literal return");
  AST_RET_TWO:
    assert property (ret |=> seqRet) else $error("return timing");
  AST_RET_FLAGS:
    assert property (ret |=> pcOut == $past(stackTopEntry) &&
      $stable({carryFlag, digitCarryFlag, zeroFlag})) else $error("return");
  AST_ROT_FILE:
    assert property (rot && instDestFile |=> fileWrEn && $stable(accOut) &&
      fileWrData == {$past(carryFlag), $past(fileReadData[7:1])} &&
      carryFlag == $past(fileReadData[0])) else $error("rotate to file");
  AST_ROT_ACC:
    assert property (rot && !instDestFile |=> !fileWrEn && $stable(zeroFlag)
      && accOut == {$past(carryFlag), $past(fileReadData[7:1])})
      else $error("rotate to acc");
  AST_SLEEP:
    assert property (tk && instOp == CRRSO_OP_SLEEP |=> watchdogClear &&
      timeoutStatusBit && !powerdownStatusBit && oscHalt) else $error("sleep");
  AST_SUB:
    assert property (tk && instOp == CRRSO_OP_SUBLIT |=>
      accOut == $past(instLiteral) - $past(accOut) && zeroFlag == (accOut == 0)
      && carryFlag == ($past(instLiteral) >= $past(accOut)) &&
      digitCarryFlag == ($past(instLiteral[3:0]) >= $past(accOut[3:0])))
      else $error("subtract");
  AST_XOR:
    assert property (tk && instOp == CRRSO_OP_XORLIT |=> $stable(carryFlag) &&
      accOut == ($past(instLiteral) ^ $past(accOut)) && $stable(digitCarryFlag)
      && zeroFlag == (accOut == 0)) else $error("xor");
endmodule
bind crrso_core crrso_properties u_crrso_properties (.*);
`default_nettype wire

// *** crrso_partner.sv ***
// File registers and return stack facing the execution unit.
`timescale 1ns/1ps
`default_nettype none
module crrso_partner (
  // Clock.
  input wire logic ref_clk,
  // File register port.
  input wire logic [6:0] rdAddr,
  input wire logic [6:0] fileAddr,
  input wire logic fileWrEn,
  input wire logic [7:0] fileWrData,
  output logic [7:0] fileReadData,
  // Return stack.
  input wire logic stackPop,
  output logic [12:0] stackTopEntry
);
  // ----
  // Storage
  // ----
  // Varied start pattern so a rotate sees both carry values.
  logic [7:0] mem [128];
  logic [2:0] sp = 3'h7;
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'(i * 37 + 11);
    end
  end
  assign fileReadData = mem[rdAddr];
  // Each level holds a distinct return address.
  assign stackTopEntry = {sp, sp, 7'h35};
  // Writes and pops land on the edge after the strobe.
  always @(posedge ref_clk) begin
    if (fileWrEn) begin
      mem[fileAddr] <= fileWrData;
    end
    if (stackPop) begin
      sp <= sp - 3'h1;
    end
  end
endmodule
`default_nettype wire

// *** crrso_tb.sv ***
// Self-checking bench for the execution unit.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import crrso_pkg::*;
  // ----
  // Signals and model state
  // ----
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic iv = 1'b0;
  crrso_op_t op = CRRSO_OP_NONE;
  logic [7:0] lit = 8'h00;
  logic [6:0] fa = 7'h00;
  logic dst = 1'b0;
  logic wake = 1'b0;
  logic took = 1'b0;
  wire logic [12:0] top, pc;
  wire logic [7:0] frd, acc, fwd;
  wire logic [6:0] fad;
  wire logic c, dcy, z, to, pdn, pl, pop, fwe, wdc, halt, busy;
  // Model flags start at their reset values.
  logic [7:0] w = 8'h00;
  logic mc = 1'b0, mdc = 1'b0, mz = 1'b0, mto = 1'b1, mpd = 1'b1;
  logic [45:0] q [$];
  logic [45:0] nxt;
  // Accumulator and status bits sit in the top thirteen bits of a note.
  localparam logic [45:0] FLAGS = {{13{1'b1}}, 33'h0_0000_0000};
  logic [31:0] seed = 32'h0000_AC1B;
  int err_total = 0;
  int num_checks = 0;
  // Write data and address count only while the write strobe stands.
  wire logic [45:0] seen = {acc, c, dcy, z, to, pdn, fwe,
    fwe ? fwd : 8'h00, fwe ? fad : 7'h00, pl, pop, pl ? pc : 13'h0000, wdc,
    halt};
  crrso_core u_crrso_core (.ref_clk(ref_clk), .rst_n(rst_n), .instValid(iv),
    .instOp(op), .instLiteral(lit), .instFileAddr(fa), .instDestFile(dst),
    .stackTopEntry(top), .fileReadData(frd), .wakeReq(wake), .accOut(acc),
    .carryFlag(c), .digitCarryFlag(dcy), .zeroFlag(z), .timeoutStatusBit(to),
    .powerdownStatusBit(pdn), .pcOut(pc), .pcLoad(pl), .stackPop(pop),
    .fileAddr(fad), .fileWrEn(fwe), .fileWrData(fwd), .watchdogClear(wdc),
    .oscHalt(halt), .busy(busy));
  crrso_partner u_crrso_partner (.ref_clk(ref_clk), .rdAddr(fa),
    .fileAddr(fad), .fileWrEn(fwe), .fileWrData(fwd), .fileReadData(frd),
    .stackPop(pop), .stackTopEntry(top));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(logic [45:0] got, logic [45:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Issue one instruction and note its expected outcome.
  task automatic run(crrso_op_t o, logic [7:0] k, logic [6:0] a, logic d);
    logic [7:0] fv, r;
    logic pl1, sl, wr;
    @(posedge ref_clk);
    fv = u_crrso_partner.mem[a];
    r = {mc, fv[7:1]};
    wr = (o == CRRSO_OP_ROTR) && d;
    pl1 = (o == CRRSO_OP_RETLIT || o == CRRSO_OP_RETURN);
    sl = (o == CRRSO_OP_SLEEP);
    case (o)
      CRRSO_OP_RETLIT: w = k;
      CRRSO_OP_ROTR: {w, mc} = {d ? w : r, fv[0]};
      CRRSO_OP_SLEEP: {mto, mpd} = 2'b10;
      CRRSO_OP_SUBLIT: {mc, mdc, w} = {k >= w, k[3:0] >= w[3:0], k - w};
      CRRSO_OP_XORLIT: w = w ^ k;
      default: ;
    endcase
    if (o == CRRSO_OP_SUBLIT || o == CRRSO_OP_XORLIT) mz = (w == 8'h00);
    q.push_back({w, mc, mdc, mz, mto, mpd, wr, wr ? r : 8'h00,
      wr ? a : 7'h00, pl1, pl1, pl1 ? top : 13'h0000, sl, sl});
    iv <= 1'b1;
    op <= o;
    lit <= k;
    fa <= a;
    dst <= d;
    if (pl1) begin
      @(posedge ref_clk);
      op <= CRRSO_OP_XORLIT;
      @(posedge ref_clk);
      iv <= 1'b0;
    end else if (sl || o == CRRSO_OP_ROTR) begin
      @(posedge ref_clk);
      iv <= 1'b0;
      wake <= sl;
      @(posedge ref_clk);
      wake <= 1'b0;
    end
  endtask
  // Watch the outputs one cycle after each accepted instruction.
  always @(posedge ref_clk) begin
    took <= rst_n && iv && !busy;
  end
  always @(negedge ref_clk) begin
    if (took && q.size() > 0) begin
      nxt = q.pop_front();
      check(seen & FLAGS, nxt & FLAGS);
      check(seen & ~FLAGS, nxt & ~FLAGS);
    end
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 1; i < 7; i++) begin
      run(crrso_op_t'(i), 8'hA5, 7'(i), 1'b1);
    end
    run(CRRSO_OP_ROTR, 8'h00, 7'h7F, 1'b0);
    run(CRRSO_OP_XORLIT, w, 7'h00, 1'b0);
    run(CRRSO_OP_SUBLIT, 8'h00, 7'h00, 1'b0);
    // An empty opcode is taken but must leave every output except fileAddr untouched.
    run(CRRSO_OP_NONE, 8'h5A, 7'h01, 1'b1);
    for (int i = 0; i < 80; i++) begin
      run(crrso_op_t'(3'(xs() % 6 + 1)), 8'(xs()), 7'(xs()), 1'(xs()));
    end
    @(posedge ref_clk);
    iv <= 1'b0;
    repeat (3) @(posedge ref_clk);
    // Every noted result must have been seen, so nothing stayed busy.
    check(46'(q.size()), 46'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
